// ### serial_config_port.v
// Three-wire serial configuration port with register file and lock logic.
// Functional notes
// - Any divider register write starts band calibration automatically.
// - Calibration lasts 94,208 phase detector cycles.
// - Status pin source select; default shows lock.
// - Two-bit LO drive level field, four levels.
// - Oscillator select value 4 means external LO.
// - Divider register writes initiate oscillator calibration.
// - Three-bit mixer bias current field.
// - Distortion amplitude and phase trim fields.
// - Two-bit gain and bandwidth select field.
// - Two-bit baseband buffer current field.
// - Deselected port ignores clock and data.
// - Frame starts at select fall, clock rise.
// - Seven address, read/write, sixteen data, MSB first.
// - Data line direction follows read/write bit.
// - Early end writes only latched bits.
// - Overlong write keeps newest sixteen bits.
// - Read shifts sixteen bits, MSB first.
// - Readback may show status, not written data.
// - Divider mode bit defaults to fractional.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_port_defines.vh"
module serial_config_port (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        sclk,
   input  wire        cs_n,
   input  wire        sdio_in,
   output reg         sdio_out,
   output reg         sdio_oe,
   input  wire        pfd_clk,
   input  wire        ref_clk,
   input  wire        pll_locked,
   output reg         status_output_pin,
   output wire        cal_busy,
   output reg         fractional_mode,
   output reg  [1:0]  lo_output_drive_level,
   output reg  [2:0]  oscillator_core_select,
   output reg         external_lo_mode,
   output reg         phase_detector_polarity,
   output reg  [2:0]  mixer_bias_current,
   output reg  [3:0]  distortion_amplitude_trim,
   output reg  [3:0]  distortion_phase_trim,
   output reg  [1:0]  gain_bandwidth_select,
   output reg  [1:0]  baseband_buffer_current,
   output reg  [15:0] internal_settings
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_DATA = 2'h2;

   reg [2:0]  sclk_s;
   reg [2:0]  cs_s;
   reg [1:0]  sdio_s;
   reg [2:0]  pfd_s;
   reg [1:0]  ref_s;
   reg [1:0]  lock_s;
   reg [1:0]  state;
   reg [6:0]  addr_sr;
   reg [3:0]  addr_cnt;
   reg        read_op;
   reg [15:0] data_sr;
   reg [4:0]  data_cnt;
   reg [15:0] rd_word;
   reg [15:0] integer_divider;
   reg [15:0] fractional_divider;
   reg [15:0] modulus_divider;
   reg [15:0] reference_and_status_output_pin_control;
   reg [15:0] lo_path_control;
   reg [15:0] mixer_tuning_control;
   reg [15:0] baseband_control;
   reg        cal_start;
   wire       cal_done;
   reg        cal_ran;

   wire sclk_rise = sclk_s[1] & ~sclk_s[2];
   wire sclk_fall = ~sclk_s[1] & sclk_s[2];
   wire cs_rise   = cs_s[1] & ~cs_s[2];
   wire selected  = ~cs_s[1];
   wire pfd_tick  = pfd_s[1] & ~pfd_s[2];

   // Merges the latched data bits into the old word, keeping the low bits.
   function [15:0] merge_word;
      input [15:0] old_word;
      input [15:0] shifted;
      input [4:0]  count;
      reg   [15:0] mask;
      begin
         mask = 16'hffff;
         if (count < 5'h10)
            mask = ~(16'hffff >> count[3:0]);
         merge_word = (old_word & ~mask) | ((shifted << (5'h10 - count))
                      & mask);
      end
   endfunction

   // Tells whether an address is one of the three divider registers.
   function is_divider;
      input [6:0] a;
      begin
         is_divider = (a == `ADDR_INTEGER_DIVIDER) ||
                      (a == `ADDR_FRACTIONAL_DIVIDER) ||
                      (a == `ADDR_MODULUS_DIVIDER);
      end
   endfunction

   // ****************************************************************
   // Synchronisers
   // ****************************************************************
   // Pins from other domains pass two flops before use.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s <= 3'h0;
         cs_s   <= 3'h7;
         sdio_s <= 2'h0;
         pfd_s  <= 3'h0;
         ref_s  <= 2'h0;
         lock_s <= 2'h0;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk};
         cs_s   <= {cs_s[1:0], cs_n};
         sdio_s <= {sdio_s[0], sdio_in};
         pfd_s  <= {pfd_s[1:0], pfd_clk};
         ref_s  <= {ref_s[0], ref_clk};
         lock_s <= {lock_s[0], pll_locked};
      end
   end

   // ****************************************************************
   // Read multiplexer
   // ****************************************************************
   // Chooses the word returned on a read; one address reports status.
   always @* begin
      case (addr_sr)
         `ADDR_INTEGER_DIVIDER:    rd_word = integer_divider;
         `ADDR_FRACTIONAL_DIVIDER: rd_word = fractional_divider;
         `ADDR_MODULUS_DIVIDER:    rd_word = modulus_divider;
         `ADDR_REF_MUX_CONTROL:    rd_word = reference_and_status_output_pin_control;
         `ADDR_LO_PATH_CONTROL:    rd_word = lo_path_control;
         `ADDR_MIXER_TUNING:       rd_word = mixer_tuning_control;
         `ADDR_BASEBAND_CONTROL:   rd_word = baseband_control;
         `ADDR_INTERNAL_SETTINGS:  rd_word = internal_settings;
         `ADDR_CAL_STATUS:
            rd_word = {13'h0000, cal_ran, lock_s[1], cal_busy};
         default:                  rd_word = 16'h0000;
      endcase
   end

   // ****************************************************************
   // Frame engine
   // ****************************************************************
   // Shifts the frame in and out; deselect ends it and commits writes.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         addr_sr   <= 7'h00;
         addr_cnt  <= 4'h0;
         read_op   <= 1'b0;
         data_sr   <= 16'h0000;
         data_cnt  <= 5'h00;
         sdio_out  <= 1'b0;
         sdio_oe   <= 1'b0;
         cal_start <= 1'b0;
         integer_divider    <= `RST_INTEGER_DIVIDER;
         fractional_divider <= `RST_FRACTIONAL_DIVIDER;
         modulus_divider    <= `RST_MODULUS_DIVIDER;
         reference_and_status_output_pin_control <= `RST_REF_MUX_CONTROL;
         lo_path_control    <= `RST_LO_PATH_CONTROL;
         mixer_tuning_control <= `RST_MIXER_TUNING;
         baseband_control   <= `RST_BASEBAND_CONTROL;
         internal_settings  <= `RST_INTERNAL_SETTINGS;
      end else begin
         cal_start <= 1'b0;
         if (!selected) begin
            sdio_oe <= 1'b0;
            state   <= ST_IDLE;
            if (cs_rise && state == ST_DATA && !read_op &&
                data_cnt != 5'h00) begin
               case (addr_sr)
                  `ADDR_INTEGER_DIVIDER: integer_divider <=
                     merge_word(integer_divider, data_sr, data_cnt);
                  `ADDR_FRACTIONAL_DIVIDER: fractional_divider <=
                     merge_word(fractional_divider, data_sr, data_cnt);
                  `ADDR_MODULUS_DIVIDER: modulus_divider <=
                     merge_word(modulus_divider, data_sr, data_cnt);
                  `ADDR_REF_MUX_CONTROL: reference_and_status_output_pin_control <=
                     merge_word(reference_and_status_output_pin_control, data_sr,
                                data_cnt);
                  `ADDR_LO_PATH_CONTROL: lo_path_control <=
                     merge_word(lo_path_control, data_sr, data_cnt);
                  `ADDR_MIXER_TUNING: mixer_tuning_control <=
                     merge_word(mixer_tuning_control, data_sr, data_cnt);
                  `ADDR_BASEBAND_CONTROL: baseband_control <=
                     merge_word(baseband_control, data_sr, data_cnt);
                  `ADDR_INTERNAL_SETTINGS: internal_settings <=
                     merge_word(internal_settings, data_sr, data_cnt);
                  default: ;
               endcase
               cal_start <= is_divider(addr_sr);
            end
         end else begin
            case (state)
               ST_IDLE: begin
                  addr_cnt <= 4'h0;
                  data_cnt <= 5'h00;
                  state    <= ST_ADDR;
               end
               ST_ADDR: begin
                  if (sclk_rise) begin
                     if (addr_cnt < `ADDR_BITS) begin
                        addr_sr  <= {addr_sr[5:0], sdio_s[1]};
                        addr_cnt <= addr_cnt + 4'h1;
                     end else begin
                        read_op  <= sdio_s[1];
                        state    <= ST_DATA;
                        data_sr  <= rd_word;
                     end
                  end
               end
               ST_DATA: begin
                  if (read_op) begin
                     if (sclk_fall) begin
                        sdio_oe  <= 1'b1;
                        sdio_out <= data_sr[15];
                        data_sr  <= {data_sr[14:0], 1'b0};
                     end
                  end else if (sclk_rise) begin
                     data_sr <= {data_sr[14:0], sdio_s[1]};
                     if (data_cnt != 5'h10)
                        data_cnt <= data_cnt + 5'h01;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // ****************************************************************
   // Band calibration
   // ****************************************************************
   band_cal_timer u_cal (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .start    (cal_start),
      .pfd_tick (pfd_tick),
      .busy     (cal_busy),
      .done     (cal_done)
   );

   // Remembers that a calibration has completed since the last start pulse.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         cal_ran <= 1'b0;
      else if (cal_done)
         cal_ran <= 1'b1;
      else if (cal_start)
         cal_ran <= 1'b0;
   end

   // ****************************************************************
   // Field outputs
   // ****************************************************************
   // Registers the control fields toward the analog sections.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status_output_pin         <= 1'b0;
         fractional_mode           <= 1'b1;
         lo_output_drive_level     <= 2'h0;
         oscillator_core_select    <= 3'h0;
         external_lo_mode          <= 1'b0;
         phase_detector_polarity   <= 1'b0;
         mixer_bias_current        <= 3'h0;
         distortion_amplitude_trim <= 4'h0;
         distortion_phase_trim     <= 4'h0;
         gain_bandwidth_select     <= 2'h0;
         baseband_buffer_current   <= 2'h0;
      end else begin
         case (reference_and_status_output_pin_control[`MUX_SEL_MSB:`MUX_SEL_LSB])
            `MUX_SEL_LOCK: status_output_pin <= lock_s[1] & ~cal_busy;
            `MUX_SEL_REF:  status_output_pin <= ref_s[1];
            `MUX_SEL_HIGH: status_output_pin <= 1'b1;
            default:       status_output_pin <= 1'b0;
         endcase
         fractional_mode <= ~integer_divider[`DIV_MODE_BIT];
         lo_output_drive_level <=
            lo_path_control[`LO_DRV_MSB:`LO_DRV_LSB];
         oscillator_core_select <=
            lo_path_control[`OSC_SEL_MSB:`OSC_SEL_LSB];
         external_lo_mode <= (lo_path_control[`OSC_SEL_MSB:`OSC_SEL_LSB]
                              == `OSC_SEL_EXTERNAL);
         phase_detector_polarity <=
            reference_and_status_output_pin_control[`PFD_POL_BIT];
         mixer_bias_current <=
            mixer_tuning_control[`MIX_BIAS_MSB:`MIX_BIAS_LSB];
         distortion_amplitude_trim <=
            mixer_tuning_control[`AMP_TRIM_MSB:`AMP_TRIM_LSB];
         distortion_phase_trim <=
            mixer_tuning_control[`PHASE_TRIM_MSB:`PHASE_TRIM_LSB];
         gain_bandwidth_select <=
            baseband_control[`GAIN_BW_MSB:`GAIN_BW_LSB];
         baseband_buffer_current <=
            baseband_control[`BB_CUR_MSB:`BB_CUR_LSB];
      end
   end
endmodule // serial_config_port
`default_nettype wire

// ### cfg_port_defines.vh
// Constants for the serial configuration port and oscillator calibration.
`ifndef CFG_PORT_DEFINES_VH
`define CFG_PORT_DEFINES_VH
// ****************************************************************
// Register addresses (7-bit)
// ****************************************************************
`define ADDR_INTEGER_DIVIDER    7'h02
`define ADDR_FRACTIONAL_DIVIDER 7'h03
`define ADDR_MODULUS_DIVIDER    7'h04
`define ADDR_REF_MUX_CONTROL    7'h21
`define ADDR_LO_PATH_CONTROL    7'h22
`define ADDR_MIXER_TUNING       7'h31
`define ADDR_BASEBAND_CONTROL   7'h34
`define ADDR_INTERNAL_SETTINGS  7'h49
`define ADDR_CAL_STATUS         7'h7f
// ****************************************************************
// Reset values
// ****************************************************************
`define RST_INTEGER_DIVIDER     16'h0000
`define RST_FRACTIONAL_DIVIDER  16'h0000
`define RST_MODULUS_DIVIDER     16'h0001
`define RST_REF_MUX_CONTROL     16'h0000
`define RST_LO_PATH_CONTROL     16'h0000
`define RST_MIXER_TUNING        16'h0000
`define RST_BASEBAND_CONTROL    16'h0000
`define RST_INTERNAL_SETTINGS   16'h0000
// ****************************************************************
// Field positions
// ****************************************************************
`define DIV_MODE_BIT            11
`define MUX_SEL_MSB             6
`define MUX_SEL_LSB             4
`define PFD_POL_BIT             3
`define LO_DRV_MSB              7
`define LO_DRV_LSB              6
`define OSC_SEL_MSB             2
`define OSC_SEL_LSB             0
`define MIX_BIAS_MSB            12
`define MIX_BIAS_LSB            10
`define AMP_TRIM_MSB            8
`define AMP_TRIM_LSB            5
`define PHASE_TRIM_MSB          3
`define PHASE_TRIM_LSB          0
`define GAIN_BW_MSB             9
`define GAIN_BW_LSB             8
`define BB_CUR_MSB              11
`define BB_CUR_LSB              10
// ****************************************************************
// Codes and counts
// ****************************************************************
`define MUX_SEL_LOCK            3'h0
`define MUX_SEL_REF             3'h1
`define MUX_SEL_LOW             3'h2
`define MUX_SEL_HIGH            3'h3
`define OSC_SEL_EXTERNAL        3'h4
`define CAL_PFD_CYCLES          17'h17000
`define ADDR_BITS               7
`define DATA_BITS               16
`endif

// ### band_cal_timer.v
// Oscillator band calibration timer counted in phase detector cycles.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_port_defines.vh"
module band_cal_timer (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        start,
   input  wire        pfd_tick,
   output reg         busy,
   output reg         done
);
   reg [16:0] count;
   // ****************************************************************
   // Counter
   // ****************************************************************
   // Restart on every start pulse; count phase detector ticks to the end.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 17'h00000;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= 17'h00000;
            busy  <= 1'b1;
         end else if (busy && pfd_tick) begin
            if (count == `CAL_PFD_CYCLES - 17'h00001) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count + 17'h00001;
            end
         end
      end
   end
endmodule // band_cal_timer
`default_nettype wire

// ### cfg_port_checker_sva.sv
// Assertion checker watching the serial configuration port pins.
`timescale 1ns/10ps
`default_nettype none
module cfg_port_checker (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        cs_n,
   input wire logic        pfd_clk,
   input wire logic        sdio_oe,
   input wire logic        cal_busy,
   input wire logic        fractional_mode,
   input wire logic [2:0]  oscillator_core_select,
   input wire logic        external_lo_mode,
   input wire logic [1:0]  lo_output_drive_level,
   input wire logic [15:0] internal_settings
);
   // Allows for one tick of slack at either end of the calibration.
   localparam int CAL_MIN = 94206;
   logic        pfd_q;
   logic [16:0] ticks;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // *****
   // Calibration tick counter
   // *****
   // Counts phase detector rising edges while calibration runs.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pfd_q <= 1'b0;
         ticks <= 17'h00000;
      end else begin
         pfd_q <= pfd_clk;
         if (!cal_busy) ticks <= 17'h00000;
         else if (pfd_clk && !pfd_q) ticks <= ticks + 17'h00001;
      end
   end
   property p_ext_lo;
      external_lo_mode == (oscillator_core_select == 3'h4);
   endproperty
   a_ext_lo: assert property (p_ext_lo) else $error("ext lo flag");
   property p_cal_start;
      $rose(cal_busy) |-> cs_n && $past(cs_n, 2);
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("start");
   property p_cal_len;
      $fell(cal_busy) |-> ticks >= CAL_MIN;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("cal too short");
   property p_cal_hold;
      $rose(cal_busy) |=> cal_busy [*8];
   endproperty
   a_cal_hold: assert property (p_cal_hold) else $error("cal dropped");
   property p_oe_idle;
      cs_n [*6] |-> !sdio_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("oe when idle");
   property p_oe_rise;
      $rose(sdio_oe) |-> !cs_n && !$past(cs_n, 30);
   endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("early");
   property p_quiet;
      cs_n [*8] |-> $stable(internal_settings) &&
                    $stable(lo_output_drive_level);
   endproperty
   a_quiet: assert property (p_quiet) else $error("change while idle");
   property p_frac_commit;
      $changed(fractional_mode) |-> cs_n && $past(cs_n, 3);
   endproperty
   a_frac_commit: assert property (p_frac_commit) else $error("mode");
   property p_set_commit;
      $changed(internal_settings) |-> cs_n && $past(cs_n, 3);
   endproperty
   a_set_commit: assert property (p_set_commit) else $error("commit");
endmodule // cfg_port_checker
`default_nettype wire

// ### host_spi_model.sv
// Host controller model that drives the three-wire configuration bus.
`timescale 1ns/10ps
`default_nettype none
module host_spi_model (
   input  wire logic mclk,
   input  wire logic sdio_out,
   input  wire logic sdio_oe,
   output var  logic sclk,
   output var  logic cs_n,
   output wire logic sdio_in
);
   logic drv_en = 1'b0;
   logic drv_bit = 1'b0;
   logic idle_q = 1'b0;
   // *****
   // Data line and frames
   // *****
   // Bus starts idle with select high and clock low.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
   end
   // An undriven line flips every cycle so stale data never matches.
   assign sdio_in = sdio_oe ? sdio_out : (drv_en ? drv_bit : ~idle_q);
   always @(posedge mclk) idle_q <= sdio_in;
   // Sends address and direction, then nbits of data or reads them.
   task automatic xfer(input logic rw, input logic [6:0] addr,
                       input logic [19:0] data, input int nbits,
                       output logic [15:0] rdata);
      logic [7:0] hdr;
      hdr = {addr, rw};
      rdata = 16'h0000;
      cs_n = 1'b0;
      for (int i = 0; i < 8 + nbits; i++) begin
         drv_en = (i < 8) || !rw;
         drv_bit = (i < 8) ? hdr[7 - i] : data[nbits + 7 - i];
         repeat (4) @(negedge mclk);
         sclk = 1'b1;
         repeat (4) @(negedge mclk);
         if (rw && i >= 8) rdata = {rdata[14:0], sdio_in};
         sclk = 1'b0;
      end
      drv_en = 1'b0;
      repeat (4) @(negedge mclk);
      cs_n = 1'b1;
      repeat (8) @(negedge mclk);
   endtask
   // Toggles clock and data with select held high.
   task automatic noise;
      drv_en = 1'b1;
      for (int i = 0; i < 24; i++) begin
         drv_bit = i[1];
         sclk = i[0];
         repeat (4) @(negedge mclk);
      end
      drv_en = 1'b0;
      sclk = 1'b0;
   endtask
endmodule // host_spi_model
`default_nettype wire

// ### serial_config_port_pll_sequencer_tb.sv
// Self-checking testbench for the serial configuration port.
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      fail_count++; \
      $display("[ERR] %s expected %h seen %h", nm, e, g); \
   end \
end
module serial_config_port_pll_sequencer_tb;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        pfd_clk = 1'b0;
   logic        ref_clk = 1'b0;
   logic        pll_locked = 1'b0;
   logic [15:0] r;
   int          fail_count = 0;
   int          check_count = 0;
   int          cyc = 0;
   wire         sclk, cs_n, sdio_in, sdio_out, sdio_oe, cal_busy, pol;
   wire         status_output_pin, fractional_mode, external_lo_mode;
   wire [1:0]   lo_output_drive_level, gbw, bb;
   wire [2:0]   oscillator_core_select, mix;
   wire [3:0]   amp, ph;
   wire [15:0]  internal_settings;
   // *****
   // Clocks, instances and tests
   // *****
   // System clock and a free phase detector clock at half its rate.
   always #25 mclk = ~mclk;
   always @(negedge mclk) pfd_clk <= ~pfd_clk;
   serial_config_port uut (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
      .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe(sdio_oe), .pfd_clk(pfd_clk), .ref_clk(ref_clk),
      .pll_locked(pll_locked), .status_output_pin(status_output_pin),
      .cal_busy(cal_busy), .fractional_mode(fractional_mode),
      .lo_output_drive_level(lo_output_drive_level),
      .oscillator_core_select(oscillator_core_select),
      .external_lo_mode(external_lo_mode), .phase_detector_polarity(pol),
      .mixer_bias_current(mix), .distortion_amplitude_trim(amp),
      .distortion_phase_trim(ph), .gain_bandwidth_select(gbw),
      .baseband_buffer_current(bb), .internal_settings(internal_settings));
   host_spi_model host (.mclk(mclk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in));
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      logic [15:0] q;
      host.xfer(1'b0, a, {4'h0, d}, 16, q);
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      host.xfer(1'b1, a, 20'h00000, 16, d);
   endtask
   task automatic t_reset;
      pll_locked = 1'b1;
      repeat (6) @(negedge mclk);
      `CHECK("frac", 1'b1, fractional_mode)
      `CHECK("oe", 1'b0, sdio_oe)
      `CHECK("pin", 1'b1, status_output_pin)
      rd(7'h04, r);
      `CHECK("mod", 16'h0001, r)
      $display("t_reset done");
   endtask
   task automatic t_lo;
      logic [2:0] o;
      for (int c = 0; c < 4; c++) begin
         o = c[0] ? 3'h4 : 3'(c);
         wr(7'h22, {8'h00, 2'(c), 3'h0, o});
         `CHECK("drv", 2'(c), lo_output_drive_level)
         `CHECK("ext", o == 3'h4, external_lo_mode)
         `CHECK("osc", o, oscillator_core_select)
         rd(7'h22, r);
         `CHECK("rb22", {8'h00, 2'(c), 3'h0, o}, r)
      end
      $display("t_lo done");
   endtask
   task automatic t_mix;
      wr(7'h31, 16'h1573);
      `CHECK("mix", 3'h5, mix)
      `CHECK("amp", 4'hb, amp)
      `CHECK("ph", 4'h3, ph)
      for (int c = 0; c < 4; c++) begin
         wr(7'h34, {4'h0, 2'(c), 2'(3 - c), 8'h00});
         `CHECK("bb", 2'(c), bb)
         `CHECK("gbw", 2'(3 - c), gbw)
      end
      $display("t_mix done");
   endtask
   task automatic t_mux;
      logic e;
      wr(7'h49, 16'h14b4);
      `CHECK("iset", 16'h14b4, internal_settings)
      for (int s = 0; s < 8; s++) begin
         wr(7'h21, {9'h000, 3'(s), 1'b1, 3'h0});
         `CHECK("pol", 1'b1, pol)
         for (int k = 0; k < 2; k++) begin
            pll_locked = k[0];
            ref_clk = !k[0];
            repeat (6) @(negedge mclk);
            e = (s == 0) ? k[0] : (s == 1) ? !k[0] : (s == 3);
            `CHECK("pin", e, status_output_pin)
         end
      end
      wr(7'h21, 16'h0008);
      $display("t_mux done");
   endtask
   task automatic t_len;
      host.xfer(1'b0, 7'h49, 20'habcde, 20, r);
      `CHECK("long", 16'hbcde, internal_settings)
      host.xfer(1'b0, 7'h49, 20'h00001, 4, r);
      `CHECK("short", 16'h1cde, internal_settings)
      host.xfer(1'b0, 7'h49, 20'h00000, 0, r);
      `CHECK("zero", 16'h1cde, internal_settings)
      host.noise();
      repeat (8) @(negedge mclk);
      `CHECK("quiet", 16'h1cde, internal_settings)
      rd(7'h49, r);
      `CHECK("rb49", 16'h1cde, r)
      $display("t_len done");
   endtask
   task automatic t_cal;
      wr(7'h02, 16'h0840);
      repeat (4) @(negedge mclk);
      `CHECK("frac", 1'b0, fractional_mode)
      `CHECK("busy", 1'b1, cal_busy)
      `CHECK("gate", 1'b0, status_output_pin)
      rd(7'h7f, r);
      `CHECK("stat", 16'h0003, r)
      rd(7'h02, r);
      `CHECK("rb02", 16'h0840, r)
      wr(7'h03, 16'h0001);
      repeat (1000) @(negedge mclk);
      `CHECK("busy", 1'b1, cal_busy)
      $display("t_cal done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Cuts a hung run short and reports it as a mismatch.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   // Reset for twenty cycles, then the scenarios in order.
   initial begin
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      repeat (2) @(negedge mclk);
      t_reset();
      t_lo();
      t_mix();
      t_mux();
      t_len();
      t_cal();
      results();
   end
endmodule // serial_config_port_pll_sequencer_tb
bind serial_config_port cfg_port_checker chk (.mclk(mclk), .rst_n(rst_n),
   .cs_n(cs_n), .pfd_clk(pfd_clk), .sdio_oe(sdio_oe), .cal_busy(cal_busy),
   .fractional_mode(fractional_mode),
   .oscillator_core_select(oscillator_core_select),
   .external_lo_mode(external_lo_mode),
   .lo_output_drive_level(lo_output_drive_level),
   .internal_settings(internal_settings));
`default_nettype wire
